// [hrsa_pkg.sv]
// package for the hardware return stack block: offsets, layouts, resets
// assumes a 32-bit axi4-lite register bus and one cpu clock
package hrsa_pkg;

	localparam int unsigned PC_WIDTH = 15;
	localparam int unsigned PTR_WIDTH = 5;
	localparam int unsigned DEPTH = 16;

	// register byte addresses
	localparam logic [7:0] OFF_STACK_POINTER = 8'h00;
	localparam logic [7:0] OFF_TOS_LOW = 8'h04;
	localparam logic [7:0] OFF_TOS_HIGH = 8'h08;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFF_CONFIG = 8'h14;

	// field positions
	localparam int unsigned BIT_OVF = 0;
	localparam int unsigned BIT_UNF = 1;
	localparam int unsigned BIT_FAULT_RST_EN = 0;

	// reset values
	localparam logic [4:0] PTR_EMPTY = 5'h1f;
	localparam logic [1:0] MASK_RESET = 2'h0;
	localparam logic CFG_RESET = 1'b0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		HRSA_OP_NONE,
		HRSA_OP_PUSH,
		HRSA_OP_POP
	} hrsa_op_t;

	// request from the cpu sequencer
	typedef struct packed {
		logic                   subr_jump;
		logic                   indirect_subroutine_jump_instr;
		logic                   irq_vector;
		logic                   subr_exit;
		logic                   exit_with_literal_instr;
		logic                   interrupt_exit_instr;
		logic [PC_WIDTH-1:0]    instruction_pointer;
	} hrsa_cpu_req_t;

	typedef struct packed {
		logic                   stack_overflow_flag;
		logic                   stack_underflow_flag;
		logic                   fault_reset;
	} hrsa_fault_t;

endpackage : hrsa_pkg

// [hrsa_stack_mem.sv]
// sixteen-entry return address store with a combinational read port
// assumes one writer per cycle; byte writes come with a lane mask
module hrsa_stack_mem #(
	parameter int unsigned DEPTH = hrsa_pkg::DEPTH,
	parameter int unsigned WIDTH = hrsa_pkg::PC_WIDTH
) (
	// clock
	input  wire logic                     aclk,
	// write port
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic [WIDTH-1:0]         wr_mask,
	// read port
	input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic      [WIDTH-1:0]         rd_data
);

	logic [WIDTH-1:0] entry [DEPTH];
	logic [WIDTH-1:0] next_entry;

	always_comb begin
		next_entry = (entry[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
	end

	always_ff @(posedge aclk) begin
		if (wr_en) begin
			entry[wr_idx] <= next_entry;
		end
	end

	assign rd_data = entry[rd_idx];

endmodule // hrsa_stack_mem

// [hrsa_axil_slave.sv]
// axi4-lite slave front end: one write and one read in flight
// assumes the core answers reads combinationally from rd_addr
module hrsa_axil_slave (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// core side
	output logic             wr_stb,
	output logic [7:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_ok,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_ok
);

	logic        aw_held, w_held;
	logic        next_aw_held, next_w_held, next_bvalid, next_rvalid, next_arready;
	logic [7:0]  next_awaddr;
	logic [31:0] next_wdata, next_rdata;
	logic [3:0]  next_wstrb;
	logic [1:0]  next_bresp, next_rresp;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_awaddr = wr_addr;
		next_wdata = wr_data;
		next_wstrb = wr_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_wdata = s_axi_wdata;
			next_wstrb = s_axi_wstrb;
		end
		if (wr_stb) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wr_ok ? hrsa_pkg::RESP_OKAY : hrsa_pkg::RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_arready = s_axi_arready;
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = rd_data;
			next_rresp = rd_ok ? hrsa_pkg::RESP_OKAY : hrsa_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_stb = aw_held && w_held && !s_axi_bvalid;
	assign rd_addr = s_axi_araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
			s_axi_arready <= 1'b1;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			wr_addr <= next_awaddr;
			wr_data <= next_wdata;
			wr_strb <= next_wstrb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			s_axi_arready <= next_arready;
		end
	end

endmodule // hrsa_axil_slave

// [hrsa_top.sv]
// hardware return-address stack with software access registers
// assumes the cpu sequencer raises at most one push or pop request a cycle
// and samples pop_value in the cycle that it raises a pop request

// What this block does
// - software reads stack pointer and top-of-stack pair, writes them only in cycles without push or pop
// - top-of-stack shown as low byte and seven-bit high byte
// - writing the pointer reselects the entry shown in the pair
// - pointer is five bits; top bit set marks the empty stack
// - direct call, indirect call and interrupt vectoring increment pointer
// - plain return, literal return and interrupt return decrement pointer
// - pointer always indexes the entry shown in the top-of-stack pair
// - push increments pointer, then stores the program counter there
// - pop reads the selected entry first, then decrements pointer
// - empty stack is pointer 0x1f; one push and one pop return there
// - sixteen entries, each fifteen bits, separate from other memories
// - with fault reset off, the stack wraps circularly on overflow
// - overflow and underflow flags set regardless of fault reset enable
module hrsa_top #(
	parameter int unsigned DEPTH = hrsa_pkg::DEPTH
) (
	// clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// axi4-lite register bus
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// cpu sequencer
	input  wire hrsa_pkg::hrsa_cpu_req_t cpu_req,
	output logic [hrsa_pkg::PC_WIDTH-1:0] pop_value,
	// status
	output hrsa_pkg::hrsa_fault_t         fault,
	output logic                         irq
);

	localparam int unsigned PCW = hrsa_pkg::PC_WIDTH;
	localparam int unsigned IW = $clog2(DEPTH);

	// ------------------------------------------------------------
	// bus front end
	// ------------------------------------------------------------
	logic        wr_stb, wr_ok, rd_ok;
	logic [7:0]  wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0]  wr_strb;

	hrsa_axil_slave u_bus (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_stb        (wr_stb),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_ok         (wr_ok),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_ok         (rd_ok)
	);

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == hrsa_pkg::OFF_STACK_POINTER) || (a == hrsa_pkg::OFF_TOS_LOW)
			|| (a == hrsa_pkg::OFF_TOS_HIGH) || (a == hrsa_pkg::OFF_IRQ_STATUS)
			|| (a == hrsa_pkg::OFF_IRQ_MASK) || (a == hrsa_pkg::OFF_CONFIG);
	endfunction

	assign wr_ok = known_addr(wr_addr);
	assign rd_ok = known_addr(rd_addr);

	// ------------------------------------------------------------
	// stack state
	// ------------------------------------------------------------
	logic [4:0]     stack_pointer, next_stack_pointer;
	logic [1:0]     irq_status, next_irq_status;
	logic [1:0]     irq_mask, next_irq_mask;
	logic           fault_reset_enable, next_fault_reset_enable;
	logic           next_fault_reset;
	hrsa_pkg::hrsa_op_t op;
	logic           mem_wr_en;
	logic [IW-1:0]  mem_wr_idx;
	logic [PCW-1:0] mem_wr_data, mem_wr_mask, stack_head_value;
	logic [1:0]     ev;

	// ------------------------------------------------------------
	// stack memory
	// ------------------------------------------------------------
	hrsa_stack_mem #(
		.DEPTH (DEPTH),
		.WIDTH (PCW)
	) u_mem (
		.aclk    (aclk),
		.wr_en   (mem_wr_en),
		.wr_idx  (mem_wr_idx),
		.wr_data (mem_wr_data),
		.wr_mask (mem_wr_mask),
		.rd_idx  (stack_pointer[IW-1:0]),
		.rd_data (stack_head_value)
	);

	// ------------------------------------------------------------
	// push, pop and software access
	// ------------------------------------------------------------
	always_comb begin
		logic [4:0] bumped;
		bumped = stack_pointer + 5'h01;
		op = hrsa_pkg::HRSA_OP_NONE;
		if (cpu_req.subr_jump || cpu_req.indirect_subroutine_jump_instr
				|| cpu_req.irq_vector) begin
			op = hrsa_pkg::HRSA_OP_PUSH;
		end else if (cpu_req.subr_exit || cpu_req.exit_with_literal_instr
				|| cpu_req.interrupt_exit_instr) begin
			op = hrsa_pkg::HRSA_OP_POP;
		end
		next_stack_pointer = stack_pointer;
		mem_wr_en = 1'b0;
		mem_wr_idx = stack_pointer[IW-1:0];
		mem_wr_data = '0;
		mem_wr_mask = '0;
		ev = 2'h0;
		unique case (op)
			hrsa_pkg::HRSA_OP_PUSH: begin
				// overflow: pointer already at the top entry
				ev[hrsa_pkg::BIT_OVF] = (stack_pointer == 5'h0f);
				// wrap to entry 0 from empty or top, keeping the stack circular
				next_stack_pointer = (stack_pointer[4] || stack_pointer == 5'h0f)
					? 5'h00 : bumped;
				mem_wr_en = 1'b1;
				mem_wr_idx = next_stack_pointer[IW-1:0];
				mem_wr_data = cpu_req.instruction_pointer;
				mem_wr_mask = '1;
			end
			hrsa_pkg::HRSA_OP_POP: begin
				ev[hrsa_pkg::BIT_UNF] = stack_pointer[4];
				next_stack_pointer = (stack_pointer == 5'h00) ? hrsa_pkg::PTR_EMPTY
					: (stack_pointer[4] ? stack_pointer : stack_pointer - 5'h01);
			end
			hrsa_pkg::HRSA_OP_NONE: begin
				if (wr_stb && wr_addr == hrsa_pkg::OFF_STACK_POINTER && wr_strb[0]) begin
					next_stack_pointer = wr_data[4:0];
				end
				if (wr_stb && wr_addr == hrsa_pkg::OFF_TOS_LOW && wr_strb[0]) begin
					mem_wr_en = 1'b1;
					mem_wr_data = {7'h00, wr_data[7:0]};
					mem_wr_mask = {7'h00, 8'hff};
				end
				if (wr_stb && wr_addr == hrsa_pkg::OFF_TOS_HIGH && wr_strb[0]) begin
					mem_wr_en = 1'b1;
					mem_wr_data = {wr_data[6:0], 8'h00};
					mem_wr_mask = {7'h7f, 8'h00};
				end
			end
		endcase
		// set beats clear on the sticky status bits
		next_irq_status = irq_status;
		if (wr_stb && wr_addr == hrsa_pkg::OFF_IRQ_STATUS && wr_strb[0]) begin
			next_irq_status = irq_status & ~wr_data[1:0];
		end
		next_irq_status = next_irq_status | ev;
		next_irq_mask = irq_mask;
		next_fault_reset_enable = fault_reset_enable;
		if (wr_stb && wr_addr == hrsa_pkg::OFF_IRQ_MASK && wr_strb[0]) begin
			next_irq_mask = wr_data[1:0];
		end
		if (wr_stb && wr_addr == hrsa_pkg::OFF_CONFIG && wr_strb[0]) begin
			next_fault_reset_enable = wr_data[hrsa_pkg::BIT_FAULT_RST_EN];
		end
		next_fault_reset = fault_reset_enable && (ev != 2'h0);
	end

	// read mux; a pop answers from the entry still selected
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (rd_addr)
			hrsa_pkg::OFF_STACK_POINTER: rd_data = {27'h0, stack_pointer};
			hrsa_pkg::OFF_TOS_LOW:       rd_data = {24'h0, stack_head_value[7:0]};
			hrsa_pkg::OFF_TOS_HIGH:      rd_data = {25'h0, stack_head_value[14:8]};
			hrsa_pkg::OFF_IRQ_STATUS:    rd_data = {30'h0, irq_status};
			hrsa_pkg::OFF_IRQ_MASK:      rd_data = {30'h0, irq_mask};
			hrsa_pkg::OFF_CONFIG:        rd_data = {31'h0, fault_reset_enable};
			default:                     rd_data = 32'h0000_0000;
		endcase
	end

	// pop value is combinational from the head: taken before the decrement
	assign pop_value = stack_head_value;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stack_pointer <= hrsa_pkg::PTR_EMPTY;
			irq_status <= 2'h0;
			irq_mask <= hrsa_pkg::MASK_RESET;
			fault_reset_enable <= hrsa_pkg::CFG_RESET;
			fault <= '0;
			irq <= 1'b0;
		end else begin
			stack_pointer <= next_stack_pointer;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			fault_reset_enable <= next_fault_reset_enable;
			fault.stack_overflow_flag <= next_irq_status[hrsa_pkg::BIT_OVF];
			fault.stack_underflow_flag <= next_irq_status[hrsa_pkg::BIT_UNF];
			fault.fault_reset <= next_fault_reset;
			irq <= |(next_irq_status & next_irq_mask);
		end
	end

endmodule // hrsa_top

// [hrsa_asserts.sv]
// assertions on the return stack block ports
// assumes a bind onto hrsa_top and a single clock domain
module hrsa_asserts (
	// clock and reset
	input wire logic                    aclk,
	input wire logic                    aresetn,
	// cpu side
	input wire hrsa_pkg::hrsa_cpu_req_t cpu_req,
	input wire logic [14:0]             pop_value,
	input wire hrsa_pkg::hrsa_fault_t   fault,
	input wire logic                    irq,
	// bus side
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_rvalid,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic [1:0]              s_axi_rresp,
	input wire logic                    s_axi_arready
);
	logic psh;
	logic pp;
	logic act;
	assign psh = cpu_req.subr_jump | cpu_req.indirect_subroutine_jump_instr | cpu_req.irq_vector;
	assign pp = cpu_req.subr_exit | cpu_req.exit_with_literal_instr | cpu_req.interrupt_exit_instr;
	assign act = psh | pp;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// stack order, fault flags, read channel
	// ----------------------------------------
	property p_push_pop;
		psh ##1 (pp && !psh) |-> pop_value == $past(cpu_req.instruction_pointer);
	endproperty
	a_push_pop: assert property (p_push_pop) else $error("pop value wrong");
	property p_push2_pop2;
		psh ##1 psh ##1 (pp && !psh) ##1 (pp && !psh)
			|-> pop_value == $past(cpu_req.instruction_pointer, 3);
	endproperty
	a_push2_pop2: assert property (p_push2_pop2) else $error("nested pop wrong");
	property p_ovf;
		$rose(fault.stack_overflow_flag) |-> $past(psh) || $past(psh, 2);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow without push");
	property p_unf;
		$rose(fault.stack_underflow_flag) |-> $past(pp) || $past(pp, 2);
	endproperty
	a_unf: assert property (p_unf) else $error("underflow without pop");
	property p_sticky;
		$fell(fault.stack_overflow_flag) || $fell(fault.stack_underflow_flag)
			|-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag cleared by itself");
	property p_irq;
		irq |-> fault.stack_overflow_flag || fault.stack_underflow_flag;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without flag");
	property p_frst;
		fault.fault_reset |-> $past(act) || $past(act, 2);
	endproperty
	a_frst: assert property (p_frst) else $error("fault reset without event");
	property p_rd_err;
		s_axi_rvalid && s_axi_rresp == hrsa_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("error read data not zero");
	property p_rd_one;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rd_one: assert property (p_rd_one) else $error("second read taken");
endmodule // hrsa_asserts

bind hrsa_top hrsa_asserts u_asserts (.*);

// [hrsa_cpu_model.sv]
// cpu sequencer stand-in: one push or pop request per call
// assumes the bench calls op and idle from one process
module hrsa_cpu_model (
	// clock
	input wire logic                aclk,
	// stack requests
	output hrsa_pkg::hrsa_cpu_req_t cpu_req,
	input wire logic [14:0]         pop_value
);
	timeunit 1ns;
	timeprecision 1ns;
	initial cpu_req = '0;
	// kinds 0..2 push, 3..5 pop, in struct bit order
	task automatic op(input int kind, input logic [14:0] ip, output logic [14:0] pv);
		hrsa_pkg::hrsa_cpu_req_t r;
		r = '0;
		r[20-kind] = 1'b1;
		r.instruction_pointer = ip;
		@(posedge aclk);
		cpu_req <= r;
		#10;
		pv = pop_value;
	endtask
	// idle value flips so a stale pointer value is never reused
	task automatic idle();
		@(posedge aclk);
		cpu_req <= {6'h00, ~cpu_req.instruction_pointer};
	endtask
endmodule // hrsa_cpu_model

// [hrsa_top_test.sv]
// self-checking bench for the hardware return stack block
// assumes hrsa_pkg, hrsa_top, hrsa_cpu_model and hrsa_asserts compiled first
module hrsa_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	hrsa_pkg::hrsa_cpu_req_t cpu_req;
	hrsa_pkg::hrsa_fault_t fault;
	logic [14:0] pop_value, pv, v;
	logic [14:0] mem [16];
	logic [4:0] ptr;
	logic [31:0] d;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	hrsa_top u_dut (.*);
	hrsa_cpu_model u_cpu (.aclk(aclk), .cpu_req(cpu_req), .pop_value(pop_value));
	initial forever #50 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wchk(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] st,
			input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dt;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(32'(s_axi_rresp), 32'(er));
		chk(s_axi_rdata, ex);
	endtask
	function automatic logic [4:0] f_push(input logic [4:0] p);
		return (p[4] || p == 5'h0f) ? 5'h00 : p + 5'h01;
	endfunction
	function automatic logic [4:0] f_pop(input logic [4:0] p);
		return (p[4] || p == 5'h00) ? 5'h1f : p - 5'h01;
	endfunction
	task automatic push(input int k);
		v = 15'($urandom);
		u_cpu.op(k, v, pv);
		ptr = f_push(ptr);
		mem[ptr[3:0]] = v;
	endtask
	task automatic pop(input int k);
		u_cpu.op(k + 3, 15'($urandom), pv);
		if (!ptr[4]) chk(32'(pv), 32'(mem[ptr[3:0]]));
		ptr = f_pop(ptr);
	endtask
	task automatic top_chk();
		rchk(hrsa_pkg::OFF_STACK_POINTER, 32'(ptr), 2'h0);
		if (!ptr[4]) begin
			rchk(hrsa_pkg::OFF_TOS_LOW, 32'(mem[ptr[3:0]][7:0]), 2'h0);
			rchk(hrsa_pkg::OFF_TOS_HIGH, 32'(mem[ptr[3:0]][14:8]), 2'h0);
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(7));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		ptr = 5'h1f;
		top_chk();
		rchk(hrsa_pkg::OFF_IRQ_STATUS, 32'h0, 2'h0);
		rchk(hrsa_pkg::OFF_IRQ_MASK, 32'h0, 2'h0);
		rchk(8'h18, 32'h0, hrsa_pkg::RESP_SLVERR);
		wchk(8'h18, 32'h1, 4'hf, hrsa_pkg::RESP_SLVERR);
		for (int k = 0; k < 3; k++) begin
			push(k);
			push(2 - k);
			pop(k);
			u_cpu.idle();
			top_chk();
			pop(2 - k);
			u_cpu.idle();
			top_chk();
		end
		// pointer moved only while the sequencer is idle
		repeat (4) push($urandom_range(0, 2));
		u_cpu.idle();
		wchk(hrsa_pkg::OFF_STACK_POINTER, 32'h1, 4'hf, 2'h0);
		ptr = 5'h01;
		top_chk();
		v = 15'($urandom);
		wchk(hrsa_pkg::OFF_TOS_LOW, 32'(v[7:0]), 4'h1, 2'h0);
		mem[1][7:0] = v[7:0];
		top_chk();
		wchk(hrsa_pkg::OFF_TOS_HIGH, 32'(v[14:8]), 4'h1, 2'h0);
		mem[1][14:8] = v[14:8];
		wchk(hrsa_pkg::OFF_STACK_POINTER, 32'h2, 4'h0, 2'h0);
		top_chk();
		repeat (3) pop($urandom_range(0, 2));
		u_cpu.idle();
		// third pop ran from the empty pointer: underflow is now sticky
		rchk(hrsa_pkg::OFF_IRQ_STATUS, 32'h2, 2'h0);
		wchk(hrsa_pkg::OFF_IRQ_STATUS, 32'h2, 4'hf, 2'h0);
		rchk(hrsa_pkg::OFF_IRQ_STATUS, 32'h0, 2'h0);
		wchk(hrsa_pkg::OFF_IRQ_MASK, 32'h3, 4'hf, 2'h0);
		repeat (17) push($urandom_range(0, 2));
		u_cpu.idle();
		top_chk();
		rchk(hrsa_pkg::OFF_IRQ_STATUS, 32'h1, 2'h0);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h1);
		chk(32'(fault.stack_overflow_flag), 32'h1);
		wchk(hrsa_pkg::OFF_IRQ_STATUS, 32'h1, 4'hf, 2'h0);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0);
		wchk(hrsa_pkg::OFF_CONFIG, 32'h1, 4'hf, 2'h0);
		pop(0);
		pop(1);
		u_cpu.idle();
		// fault reset pulse stands for the one cycle after the underflow pop
		@(negedge aclk);
		chk(32'(fault.fault_reset), 32'h1);
		rchk(hrsa_pkg::OFF_IRQ_STATUS, 32'h2, 2'h0);
		chk(32'(fault.stack_underflow_flag), 32'h1);
		chk(32'(irq), 32'h1);
		repeat (60) begin
			if ($urandom_range(0, 1)) push($urandom_range(0, 2));
			else pop($urandom_range(0, 2));
			if ($urandom_range(0, 2) == 0) u_cpu.idle();
		end
		u_cpu.idle();
		top_chk();
		end_sim();
	end
endmodule // hrsa_top_test
